// ===== tb/test_flash_verify_readonce_cmds.sv
// Self-checking bench for the flash command engine, with a behavioural flash array
// Assumes a same-clock array that answers each held read and reads erased words as all ones
`timescale 1ns/1ps
`include "fvr_params.svh"
module test_flash_verify_readonce_cmds;
  logic clk_i, rst_i, cyc, stb, we, wb_ack_o, pf_read_invalid_o, command_complete_flag_o;
  logic [3:0] adr, sel;
  logic [31:0] dat, wb_dat_o;
  fvr_pkg::fvr_flash_req_t fl_req_o;
  fvr_pkg::fvr_flash_rsp_t rsp;
  int miscompares, cmp_count, nacks;
  logic [17:0] dirty, bad, first;
  logic fat, slow, gap, inv_seen;

  fvr_cmd_engine fvr_cmd_engine_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fl_req_o(fl_req_o), .fl_rsp_i(rsp), .pf_read_invalid_o(pf_read_invalid_o),
    .command_complete_flag_o(command_complete_flag_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [15:0] word_at(input logic info, input logic [17:0] a);
    if (info) return {8'ha5, a[7:0]};
    return (a == dirty) ? 16'h0000 : 16'hffff;
  endfunction

  // Array model: optional stall every other cycle, data toggles while idle
  always @(posedge clk_i) begin
    gap <= ~gap;
    rsp <= {3'b000, ~rsp.data};
    if (fl_req_o.rd === 1'b1 && rsp.ack !== 1'b1 && (!slow || gap)) begin
      rsp.ack <= 1'b1;
      rsp.data <= word_at(fl_req_o.info, fl_req_o.addr);
      rsp.err <= (fl_req_o.addr == bad);
      rsp.fatal <= fat && (fl_req_o.addr == bad);
      if (nacks == 0) first <= fl_req_o.addr;
      nacks <= nacks + 1;
    end
  end

  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      stop_test();
    end
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rdc

  // Load words 0..2 and the launch index, launch, wait, judge status and scan
  task automatic cmd(input logic [15:0] w0, w1, w2, input logic [2:0] ix, input logic [31:0] exp,
                     input int words, input logic [17:0] fa);
    int n;
    wr(`FVR_OFS_INDEX, 32'h0);
    wr(`FVR_OFS_WORD, {16'h0, w0});
    wr(`FVR_OFS_INDEX, 32'h1);
    wr(`FVR_OFS_WORD, {16'h0, w1});
    wr(`FVR_OFS_INDEX, 32'h2);
    wr(`FVR_OFS_WORD, {16'h0, w2});
    wr(`FVR_OFS_INDEX, {29'h0, ix});
    nacks = 0;
    inv_seen = 1'b0;
    wr(`FVR_OFS_STAT, 32'h80);
    n = 0;
    while (command_complete_flag_o !== 1'b1 && n < 70000) begin
      @(posedge clk_i);
      n++;
      if (pf_read_invalid_o === 1'b1) inv_seen = 1'b1;
    end
    if (n >= 70000) begin
      miscompares++;
      stop_test();
    end
    rdc(`FVR_OFS_STAT, exp);
    chk(32'(nacks), 32'(words));
    if (fa != 18'h0) chk({14'h0, first}, {14'h0, fa});
    chk({31'h0, inv_seen}, {31'h0, w0[15:8] == `FVR_CMD_RONCE && !exp[5]});
    chk({31'h0, pf_read_invalid_o}, 32'h0);
    wr(`FVR_OFS_STAT, 32'h20);
  endtask : cmd

  task automatic t_reset();
    rdc(`FVR_OFS_STAT, 32'h80);
    rdc(`FVR_OFS_INDEX, 32'h0);
    rdc(`FVR_OFS_WORD, 32'h0);
    rdc(4'h2, 32'h0);
    wr(`FVR_OFS_MODE, 32'h1);
    rdc(`FVR_OFS_MODE, 32'h1);
    wr(`FVR_OFS_MODE, 32'h0);
  endtask : t_reset

  task automatic t_block();
    cmd(16'h0200, 16'h0, 16'h0, 3'h0, 32'h80, 32'h200, 18'h00400);
    cmd(16'h0201, 16'h0, 16'h0, 3'h0, 32'ha0, 0, 18'h0);
    cmd(16'h0202, 16'h0, 16'h0, 3'h0, 32'ha0, 0, 18'h0);
    cmd(16'h0200, 16'h0, 16'h0, 3'h1, 32'ha0, 0, 18'h0);
    dirty = 18'h00410;
    cmd(16'h0200, 16'h0, 16'h0, 3'h0, 32'h83, 32'h200, 18'h00400);
    dirty = 18'h3ffff;
    bad = 18'h00402;
    cmd(16'h0200, 16'h0, 16'h0, 3'h0, 32'h82, 32'h200, 18'h00400);
    fat = 1'b1;
    cmd(16'h0200, 16'h0, 16'h0, 3'h0, 32'h83, 32'h200, 18'h00400);
    fat = 1'b0;
    bad = 18'h3ffff;
  endtask : t_block

  task automatic t_all();
    logic [7:0] codes [3] = '{8'h00, 8'h05, 8'hff};
    foreach (codes[i]) cmd({codes[i], 8'h0}, 16'h0, 16'h0, 3'h0, 32'ha0, 0, 18'h0);
    cmd(16'h0100, 16'h0, 16'h0, 3'h3, 32'ha0, 0, 18'h0);
    dirty = 18'h30020;
    cmd(16'h0100, 16'h0, 16'h0, 3'h0, 32'h83, 32'h8200, 18'h0);
    dirty = 18'h3ffff;
  endtask : t_all

  task automatic t_section();
    slow = 1'b1;
    dirty = 18'h30014;
    cmd(16'h0303, 16'h0010, 16'h2, 3'h2, 32'h83, 8, 18'h30010);
    dirty = 18'h3ffff;
    cmd(16'h0303, 16'hfff8, 16'h1, 3'h2, 32'h80, 4, 18'h3fff8);
    cmd(16'h0303, 16'hfff8, 16'h2, 3'h2, 32'ha0, 0, 18'h0);
    cmd(16'h0303, 16'h0012, 16'h1, 3'h2, 32'ha0, 0, 18'h0);
    cmd(16'h0302, 16'h0010, 16'h1, 3'h2, 32'ha0, 0, 18'h0);
    cmd(16'h0303, 16'h0010, 16'h1, 3'h1, 32'ha0, 0, 18'h0);
    cmd(16'h0303, 16'h0010, 16'h0, 3'h2, 32'h80, 0, 18'h0);
    wr(`FVR_OFS_MODE, 32'h1);
    cmd(16'h0303, 16'h0010, 16'h1, 3'h2, 32'ha0, 0, 18'h0);
    cmd(16'h0400, 16'h0003, 16'h0, 3'h1, 32'ha0, 0, 18'h0);
    wr(`FVR_OFS_MODE, 32'h0);
    slow = 1'b0;
  endtask : t_section

  // Program-flash block verify starts at the block base; a reset cuts it short
  task automatic t_pfblk();
    wr(`FVR_OFS_INDEX, 32'h0);
    wr(`FVR_OFS_WORD, 32'h0203);
    nacks = 0;
    wr(`FVR_OFS_STAT, 32'h80);
    repeat (20) @(posedge clk_i);
    chk({31'h0, command_complete_flag_o}, 32'h0);
    chk({14'h0, first}, 32'h00030000);
    chk({31'h0, nacks > 5}, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, command_complete_flag_o}, 32'h1);
    chk({31'h0, pf_read_invalid_o}, 32'h0);
    rdc(`FVR_OFS_STAT, 32'h80);
    rdc(`FVR_OFS_WORD, 32'h0);
  endtask : t_pfblk

  task automatic t_ronce();
    logic [17:0] a;
    cmd(16'h0400, 16'h0003, 16'h0, 3'h1, 32'h80, 4, 18'h00018);
    for (int k = 2; k <= 5; k++) begin
      a = 18'h00018 + 18'(2 * (k - 2));
      wr(`FVR_OFS_INDEX, 32'(k));
      rdc(`FVR_OFS_WORD, {16'h0, word_at(1'b1, a)});
    end
    bad = 18'h0001a;
    cmd(16'h0400, 16'h0003, 16'h0, 3'h1, 32'h82, 4, 18'h00018);
    bad = 18'h3ffff;
    cmd(16'h0400, 16'h0007, 16'h0, 3'h1, 32'h80, 4, 18'h00038);
    wr(`FVR_OFS_INDEX, 32'h5);
    rdc(`FVR_OFS_WORD, {16'h0, word_at(1'b1, 18'h0003e)});
    cmd(16'h0400, 16'h0008, 16'h0, 3'h1, 32'ha0, 0, 18'h0);
    cmd(16'h0400, 16'h0003, 16'h0, 3'h0, 32'ha0, 0, 18'h0);
  endtask : t_ronce

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'h0;
    dat = 32'h0;
    rsp = '0;
    miscompares = 0;
    cmp_count = 0;
    nacks = 0;
    dirty = 18'h3ffff;
    bad = 18'h3ffff;
    first = 18'h0;
    fat = 1'b0;
    slow = 1'b0;
    gap = 1'b0;
    inv_seen = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_block();
    t_section();
    t_pfblk();
    t_ronce();
    t_all();
    stop_test();
  end
endmodule : test_flash_verify_readonce_cmds

// ===== verilog/fvr_cmd_engine.sv
// Flash command engine: erase-verify all, block, section; read-once
// Assumes a classic Wishbone master and a same-clock flash array port
// How it works
// - Clearing complete flag launches; set when finished
// - Code 01 verifies all blocks, index 000
// - Not-erased location sets both verify flags
// - Read error sets verify; fatal sets uncorrectable
// - Block select 00 data, 11 program, else error
// - Block verify checks one block, index 000
// - Section uses words 000 to 010, index 010
// - Section start with low bits set errors
// - Section past program flash end errors
// - Section start outside program flash errors
// - Locked mode refuses section and read-once
// - Read-once index 001, phrase 0 to 7
// - Read-once phrase lands in words 010-101
// - Read-once area: eight phrases, information region
// - Program flash reads invalid during read-once
// - Undefined command code sets access error
`timescale 1ns/1ps
`include "fvr_params.svh"
module fvr_cmd_engine (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [3:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output fvr_pkg::fvr_flash_req_t fl_req_o, // Flash array request
  input wire fvr_pkg::fvr_flash_rsp_t fl_rsp_i, // Flash array answer
  output logic pf_read_invalid_o, // Program flash reads invalid
  output logic command_complete_flag_o // Idle level
);
  fvr_pkg::fvr_state_t state;
  logic access_error_flag;
  logic protection_violation_flag;
  logic verify_error_flag;
  logic uncorrectable_error_flag;
  logic [2:0] command_word_index;
  logic [15:0] command_parameter_words [6];
  logic cmd_lock;
  logic scan_start;
  logic scan_info;
  logic [17:0] scan_base;
  logic [17:0] scan_words;
  logic [1:0] ro_ptr;
  logic [15:0] s_word;
  logic s_stb;
  logic s_done;
  logic s_err;
  logic s_fatal;
  logic s_blank;
  logic req;
  logic wr;
  logic launch;
  logic bad;
  logic finish;
  logic blank_hit;
  logic [7:0] cmd;
  logic [1:0] block_select_code;
  logic [17:0] sec_start;
  logic [19:0] sec_end;

  fvr_scan u_scan (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(scan_start),
    .info_i(scan_info),
    .base_i(scan_base),
    .words_i(scan_words),
    .req_o(fl_req_o),
    .rsp_i(fl_rsp_i),
    .word_o(s_word),
    .word_stb_o(s_stb),
    .done_o(s_done),
    .err_o(s_err),
    .fatal_o(s_fatal),
    .blank_fail_o(s_blank)
  );

  // Bus request decode; write lands on the edge that raises ack
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  // Launch needs an idle engine and no pending access or protection error
  assign launch = wr & (wb_adr_i == `FVR_OFS_STAT) & wb_sel_i[0] & wb_dat_i[`FVR_B_COMMAND_COMPLETE_FLAG]
    & command_complete_flag_o & ~access_error_flag & ~protection_violation_flag;

  assign cmd = command_parameter_words[0][15:8];
  assign block_select_code = command_parameter_words[0][1:0];
  assign sec_start = {command_parameter_words[0][1:0], command_parameter_words[1]};
  assign sec_end = {2'h0, sec_start} + {1'b0, command_parameter_words[2], 3'h0};

  // Parameter checks taken at launch
  always_comb begin
    bad = 1'b0;
    case (cmd)
      `FVR_CMD_VALL: bad = (command_word_index != `FVR_IX_VALL);
      `FVR_CMD_VBLK: bad = (command_word_index != `FVR_IX_VBLK)
        || (block_select_code != `FVR_SEL_DF && block_select_code != `FVR_SEL_PF);
      `FVR_CMD_VSEC: bad = (command_word_index != `FVR_IX_VSEC) || cmd_lock
        || (sec_start[2:0] != 3'h0)
        || (sec_start < `FVR_PF_BASE)
        || (sec_end > {2'h0, `FVR_PF_LAST} + 20'h00001);
      `FVR_CMD_RONCE: bad = (command_word_index != `FVR_IX_RONCE) || cmd_lock
        || (command_parameter_words[1] > `FVR_RO_MAX);
      default: bad = 1'b1;
    endcase
  end

  // Last scan of a command
  assign finish = s_done & (state != fvr_pkg::ST_IDLE)
    & ~(state == fvr_pkg::ST_DF && cmd == `FVR_CMD_VALL);
  // Blank check does not apply to read-once
  assign blank_hit = s_blank & (state != fvr_pkg::ST_RO);

  // Bus handshake and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h00000000;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          `FVR_OFS_STAT: begin
            wb_dat_o[`FVR_B_COMMAND_COMPLETE_FLAG] <= command_complete_flag_o;
            wb_dat_o[`FVR_B_ACCESS_ERROR_FLAG] <= access_error_flag;
            wb_dat_o[`FVR_B_PROTECTION_VIOLATION_FLAG] <= protection_violation_flag;
            wb_dat_o[`FVR_B_VERR] <= verify_error_flag;
            wb_dat_o[`FVR_B_UNC] <= uncorrectable_error_flag;
          end
          `FVR_OFS_INDEX: wb_dat_o[2:0] <= command_word_index;
          `FVR_OFS_WORD: begin
            if (command_word_index < 3'h6) begin
              wb_dat_o[15:0] <= command_parameter_words[command_word_index];
            end
          end
          `FVR_OFS_MODE: wb_dat_o[0] <= cmd_lock;
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Status flags; hardware set wins over a same-cycle software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      command_complete_flag_o <= `FVR_RST_COMMAND_COMPLETE_FLAG;
      access_error_flag <= `FVR_RST_FLAG;
      protection_violation_flag <= `FVR_RST_FLAG;
      verify_error_flag <= `FVR_RST_FLAG;
      uncorrectable_error_flag <= `FVR_RST_FLAG;
    end else begin
      if (wr && wb_adr_i == `FVR_OFS_STAT && wb_sel_i[0]) begin
        if (wb_dat_i[`FVR_B_ACCESS_ERROR_FLAG]) begin
          access_error_flag <= 1'b0;
        end
        if (wb_dat_i[`FVR_B_PROTECTION_VIOLATION_FLAG]) begin
          protection_violation_flag <= 1'b0;
        end
      end
      if (launch && bad) begin
        access_error_flag <= 1'b1;
      end else if (launch) begin
        command_complete_flag_o <= 1'b0;
        verify_error_flag <= 1'b0;
        uncorrectable_error_flag <= 1'b0;
      end
      if (s_done && state != fvr_pkg::ST_IDLE) begin
        verify_error_flag <= verify_error_flag | s_err | blank_hit;
        uncorrectable_error_flag <= uncorrectable_error_flag | s_fatal | blank_hit;
      end
      if (finish) begin
        command_complete_flag_o <= 1'b1;
      end
    end
  end

  // Index, mode and command words; read-once results land here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      command_word_index <= `FVR_RST_INDEX;
      cmd_lock <= `FVR_RST_LOCK;
      for (int i = 0; i < 6; i++) begin
        command_parameter_words[i] <= `FVR_RST_WORD;
      end
    end else begin
      if (wr && command_complete_flag_o) begin
        case (wb_adr_i)
          `FVR_OFS_INDEX: begin
            if (wb_sel_i[0]) begin
              command_word_index <= wb_dat_i[2:0];
            end
          end
          `FVR_OFS_WORD: begin
            if (command_word_index < 3'h6) begin
              if (wb_sel_i[0]) begin
                command_parameter_words[command_word_index][7:0] <= wb_dat_i[7:0];
              end
              if (wb_sel_i[1]) begin
                command_parameter_words[command_word_index][15:8] <= wb_dat_i[15:8];
              end
            end
          end
          `FVR_OFS_MODE: begin
            if (wb_sel_i[0]) begin
              cmd_lock <= wb_dat_i[0];
            end
          end
          default: cmd_lock <= cmd_lock;
        endcase
      end
      if (state == fvr_pkg::ST_RO && s_stb) begin
        command_parameter_words[`FVR_IX_RO_W0 + {1'b0, ro_ptr}] <= s_word;
      end
    end
  end

  // Command sequencing and scan set-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= fvr_pkg::ST_IDLE;
      scan_start <= 1'b0;
      scan_info <= 1'b0;
      scan_base <= 18'h00000;
      scan_words <= 18'h00000;
      ro_ptr <= 2'h0;
      pf_read_invalid_o <= 1'b0;
    end else begin
      scan_start <= 1'b0;
      if (state == fvr_pkg::ST_RO && s_stb) begin
        ro_ptr <= ro_ptr + 2'h1;
      end
      unique case (state)
        fvr_pkg::ST_IDLE: begin
          if (launch && !bad) begin
            scan_start <= 1'b1;
            scan_info <= 1'b0;
            ro_ptr <= 2'h0;
            if (cmd == `FVR_CMD_VALL || (cmd == `FVR_CMD_VBLK && block_select_code == `FVR_SEL_DF)) begin
              scan_base <= `FVR_DF_BASE;
              scan_words <= `FVR_DF_WORDS;
              state <= fvr_pkg::ST_DF;
            end else if (cmd == `FVR_CMD_VBLK) begin
              scan_base <= `FVR_PF_BASE;
              scan_words <= `FVR_PF_WORDS;
              state <= fvr_pkg::ST_PF;
            end else if (cmd == `FVR_CMD_VSEC) begin
              scan_base <= sec_start;
              scan_words <= {command_parameter_words[2], 2'h0};
              state <= fvr_pkg::ST_PF;
            end else begin
              scan_info <= 1'b1;
              scan_base <= `FVR_RO_BASE + {12'h000, command_parameter_words[1][2:0], 3'h0};
              scan_words <= `FVR_RO_WORDS;
              pf_read_invalid_o <= 1'b1;
              state <= fvr_pkg::ST_RO;
            end
          end
        end
        fvr_pkg::ST_DF: begin
          if (s_done && cmd == `FVR_CMD_VALL) begin
            scan_start <= 1'b1;
            scan_base <= `FVR_PF_BASE;
            scan_words <= `FVR_PF_WORDS;
            state <= fvr_pkg::ST_PF;
          end else if (s_done) begin
            state <= fvr_pkg::ST_IDLE;
          end
        end
        fvr_pkg::ST_PF: begin
          if (s_done) begin
            state <= fvr_pkg::ST_IDLE;
          end
        end
        fvr_pkg::ST_RO: begin
          if (s_done) begin
            pf_read_invalid_o <= 1'b0;
            state <= fvr_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  launch_clears_a: assert property (launch && !bad |=> !command_complete_flag_o
    ##1 (!command_complete_flag_o && state != fvr_pkg::ST_IDLE)) else $error("launch did not start");
  finish_sets_a: assert property (finish |=> command_complete_flag_o && state == fvr_pkg::ST_IDLE)
    else $error("finish did not set complete");
  all_index_a: assert property (launch && cmd == `FVR_CMD_VALL && command_word_index != 3'h0
    |=> access_error_flag && command_complete_flag_o) else $error("verify-all index not refused");
  block_sel_a: assert property (launch && cmd == `FVR_CMD_VBLK && (block_select_code == 2'h1
    || block_select_code == 2'h2) |=> access_error_flag && state == fvr_pkg::ST_IDLE)
    else $error("bad block select ran");
  sec_align_a: assert property (launch && cmd == `FVR_CMD_VSEC && sec_start[2:0] != 3'h0
    |=> access_error_flag ##1 state == fvr_pkg::ST_IDLE) else $error("misaligned section ran");
  ro_range_a: assert property (launch && cmd == `FVR_CMD_RONCE
    && command_parameter_words[1] > 16'h0007 |=> access_error_flag) else $error("phrase index not refused");
  undef_cmd_a: assert property (launch && cmd > 8'h04 |=> access_error_flag
    && state == fvr_pkg::ST_IDLE) else $error("undefined command ran");
  blank_both_a: assert property (s_done && s_blank && (state == fvr_pkg::ST_DF
    || state == fvr_pkg::ST_PF) |=> verify_error_flag && uncorrectable_error_flag)
    else $error("blank fail not flagged");
  ro_invalid_a: assert property (state == fvr_pkg::ST_RO |-> pf_read_invalid_o
    && !command_complete_flag_o) else $error("reads not marked invalid");
  no_protection_violation_flag_a: assert property (!protection_violation_flag) else $error("protection flag set");
  // Parameter refusals and result checks
  lock_refuse_a: assert property (launch && cmd_lock
    && (cmd == `FVR_CMD_VSEC || cmd == `FVR_CMD_RONCE) |=> access_error_flag && state == fvr_pkg::ST_IDLE)
    else $error("locked command ran");
  sec_range_a: assert property (launch && cmd == `FVR_CMD_VSEC && (sec_start < `FVR_PF_BASE
    || sec_end > {2'h0, `FVR_PF_LAST} + 20'h00001) |=> access_error_flag && state == fvr_pkg::ST_IDLE)
    else $error("section outside program flash ran");
  sec_index_a: assert property (launch && cmd == `FVR_CMD_VSEC && command_word_index != `FVR_IX_VSEC
    |=> access_error_flag) else $error("section index not refused");
  blk_index_a: assert property (launch && cmd == `FVR_CMD_VBLK && command_word_index != `FVR_IX_VBLK
    |=> access_error_flag && command_complete_flag_o) else $error("block verify index not refused");
  ro_index_a: assert property (launch && cmd == `FVR_CMD_RONCE && command_word_index != `FVR_IX_RONCE
    |=> access_error_flag) else $error("read-once index not refused");
  read_err_a: assert property (s_done && s_err && state != fvr_pkg::ST_IDLE
    |=> verify_error_flag) else $error("read error not flagged");
  ro_land_a: assert property (state == fvr_pkg::ST_RO && s_stb
    |=> command_parameter_words[`FVR_IX_RO_W0 + {1'b0, $past(ro_ptr)}] == $past(s_word))
    else $error("read-once word lost");
  ro_release_a: assert property (state == fvr_pkg::ST_RO && s_done
    |=> !pf_read_invalid_o && command_complete_flag_o) else $error("read-once did not release reads");

  all_done_c: cover property (state == fvr_pkg::ST_PF && finish && cmd == `FVR_CMD_VALL);
  ro_done_c: cover property (state == fvr_pkg::ST_RO && finish);
  sec_err_c: cover property (launch && bad && cmd == `FVR_CMD_VSEC);
  blank_c: cover property (finish && blank_hit);
  sec_done_c: cover property (state == fvr_pkg::ST_PF && finish && cmd == `FVR_CMD_VSEC);
endmodule : fvr_cmd_engine

// ===== verilog/fvr_params.svh
// Register offsets, field positions, reset values, command codes, flash map
// Assumes a 32-bit classic Wishbone slave port with byte addresses
`ifndef FVR_PARAMS_SVH
`define FVR_PARAMS_SVH
`define FVR_OFS_STAT 4'h0
`define FVR_OFS_INDEX 4'h4
`define FVR_OFS_WORD 4'h8
`define FVR_OFS_MODE 4'hc
`define FVR_B_COMMAND_COMPLETE_FLAG 7
`define FVR_B_ACCESS_ERROR_FLAG 5
`define FVR_B_PROTECTION_VIOLATION_FLAG 4
`define FVR_B_VERR 1
`define FVR_B_UNC 0
`define FVR_RST_COMMAND_COMPLETE_FLAG 1'b1
`define FVR_RST_FLAG 1'b0
`define FVR_RST_INDEX 3'h0
`define FVR_RST_WORD 16'h0000
`define FVR_RST_LOCK 1'b0
`define FVR_CMD_VALL 8'h01
`define FVR_CMD_VBLK 8'h02
`define FVR_CMD_VSEC 8'h03
`define FVR_CMD_RONCE 8'h04
`define FVR_SEL_DF 2'h0
`define FVR_SEL_PF 2'h3
`define FVR_IX_VALL 3'h0
`define FVR_IX_VBLK 3'h0
`define FVR_IX_VSEC 3'h2
`define FVR_IX_RONCE 3'h1
`define FVR_IX_RO_W0 3'h2
`define FVR_PF_BASE 18'h30000
`define FVR_PF_LAST 18'h3ffff
`define FVR_PF_WORDS 18'h08000
`define FVR_DF_BASE 18'h00400
`define FVR_DF_WORDS 18'h00200
`define FVR_RO_BASE 18'h00000
`define FVR_RO_MAX 16'h0007
`define FVR_RO_WORDS 18'h00004
`define FVR_ERASED 16'hffff
`endif

// ===== verilog/fvr_pkg.sv
// Types shared by the command engine and its flash scanner
// Assumes one clock domain for the engine and the flash array port
package fvr_pkg;
  typedef struct packed {
    logic rd;
    logic info;
    logic [17:0] addr;
  } fvr_flash_req_t;
  typedef struct packed {
    logic ack;
    logic err;
    logic fatal;
    logic [15:0] data;
  } fvr_flash_rsp_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DF = 4'b0010,
    ST_PF = 4'b0100,
    ST_RO = 4'b1000
  } fvr_state_t;
endpackage : fvr_pkg

// ===== verilog/fvr_scan.sv
// Flash word scanner: walks a word range, reports read and blank errors
// Assumes the array acks each held word read, for the address shown that cycle
`timescale 1ns/1ps
`include "fvr_params.svh"
module fvr_scan (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic start_i, // Begin a scan
  input wire logic info_i, // Scan the information region
  input wire logic [17:0] base_i, // First byte address
  input wire logic [17:0] words_i, // Number of 16-bit words
  output fvr_pkg::fvr_flash_req_t req_o, // Array read request
  input wire fvr_pkg::fvr_flash_rsp_t rsp_i, // Array answer
  output logic [15:0] word_o, // Last word read
  output logic word_stb_o, // Word strobe
  output logic done_o, // Scan finished pulse
  output logic err_o, // Any read error
  output logic fatal_o, // Any uncorrectable read error
  output logic blank_fail_o // Some word not erased
);
  logic [17:0] left;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_o <= '0;
      left <= 18'h00000;
      word_o <= 16'h0000;
      word_stb_o <= 1'b0;
      done_o <= 1'b0;
      err_o <= 1'b0;
      fatal_o <= 1'b0;
      blank_fail_o <= 1'b0;
    end else begin
      word_stb_o <= 1'b0;
      done_o <= 1'b0;
      if (start_i) begin
        req_o.addr <= base_i;
        req_o.info <= info_i;
        req_o.rd <= (words_i != 18'h00000);
        done_o <= (words_i == 18'h00000);
        left <= words_i;
        err_o <= 1'b0;
        fatal_o <= 1'b0;
        blank_fail_o <= 1'b0;
      end else if (req_o.rd && rsp_i.ack) begin
        word_o <= rsp_i.data;
        word_stb_o <= 1'b1;
        err_o <= err_o | rsp_i.err;
        fatal_o <= fatal_o | rsp_i.fatal;
        blank_fail_o <= blank_fail_o | (rsp_i.data != `FVR_ERASED);
        left <= left - 18'h00001;
        req_o.addr <= req_o.addr + 18'h00002;
        if (left == 18'h00001) begin
          req_o.rd <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule : fvr_scan
